// ### misc_ctrl_pkg.sv
// misc_ctrl_pkg.sv: register map, field positions, reset values and timing for the misc control bank
// assumes a 25 MHz system clock; shared by the bank and its i2c target
package misc_ctrl_pkg;
	localparam logic [7:0] discharge_path_control_addr = 8'h98;
	localparam logic [7:0] thermal_sensor_control_addr = 8'h99;
	localparam logic [7:0] slow_timer_low_byte_addr = 8'ha0;
	localparam logic [7:0] slow_timer_high_byte_addr = 8'ha1;
	localparam logic [7:0] register_page_choice_addr = 8'hff;
	localparam logic [7:0] misc_status_addr = 8'ha2;
	localparam logic [7:0] soft_reset_control_addr = 8'ha3;
	localparam logic [7:0] reg_reset_value = 8'h00;
	localparam int vbus_off_bit = 0;
	localparam int vconn_off_bit = 1;
	localparam int thermal_on_bit = 0;
	localparam int thermal_live_bit = 4;
	localparam int page_bit = 0;
	localparam int expired_bit = 0;
	localparam int soft_reset_bit = 5;
	localparam logic [7:0] i2c_target_address = 8'h20;
	localparam int clk_hz = 25000000;
	localparam int tick_us = 1000;
	localparam int tick_cycles = clk_hz / 1000000 * tick_us;
endpackage : misc_ctrl_pkg

// ### misc_i2c_target.sv
// misc_i2c_target.sv: i2c target, byte-wide register access with auto-incrementing pointer
// assumes scl and sda inputs already synchronous to clk; sda is open drain
`timescale 1ns/10ps
`default_nettype none
module misc_i2c_target (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset
	input wire logic scl_in, // bus clock level
	input wire logic sda_in, // bus data level
	output logic sda_oe, // high pulls sda low
	output logic wr_stb, // one-cycle register write
	output logic rd_stb, // one-cycle register read taken
	output logic [7:0] addr, // register pointer
	output logic [7:0] wdata, // write data
	input wire logic [7:0] rdata // read data at pointer
);
	typedef enum logic [2:0] {
		st_idle = 3'b000, st_dev = 3'b001, st_ack = 3'b010, st_ptr = 3'b011,
		st_wr = 3'b100, st_rd = 3'b101, st_rack = 3'b110
	} i2c_e;
	i2c_e state, next_state;
	logic scl_q, sda_q, next_scl_q, next_sda_q;
	logic [7:0] sh, next_sh, next_addr, next_wdata;
	logic [3:0] cnt, next_cnt;
	logic rnw, next_rnw, next_oe, next_wr, next_rd, ptr_done, next_ptr_done;
	logic rise, fall, start, stop;
	assign rise = scl_in && !scl_q;
	assign fall = !scl_in && scl_q;
	assign start = scl_in && scl_q && sda_q && !sda_in;
	assign stop = scl_in && scl_q && !sda_q && sda_in;
	always_comb begin
		next_scl_q = scl_in;
		next_sda_q = sda_in;
		next_state = state;
		next_sh = sh;
		next_cnt = cnt;
		next_addr = addr;
		next_wdata = wdata;
		next_rnw = rnw;
		next_oe = sda_oe;
		next_wr = 1'b0;
		next_rd = 1'b0;
		next_ptr_done = ptr_done;
		if (start) begin
			next_state = st_dev;
			next_cnt = 4'h0;
			next_oe = 1'b0;
			next_ptr_done = 1'b0;
		end else if (stop) begin
			next_state = st_idle;
			next_oe = 1'b0;
		end else begin
			unique case (state)
				st_idle: begin
				end
				st_dev, st_ptr, st_wr: begin
					if (rise) begin
						next_sh = {sh[6:0], sda_in};
						next_cnt = cnt + 4'h1;
					end
					if (fall && cnt == 4'h8) begin
						next_cnt = 4'h0;
						if (state == st_dev) begin
							next_rnw = sh[0];
							next_oe = (sh[7:1] == misc_ctrl_pkg::i2c_target_address[6:0]);
							next_state = next_oe ? st_ack : st_idle;
						end else if (state == st_ptr) begin
							next_addr = sh;
							next_ptr_done = 1'b1;
							next_oe = 1'b1;
							next_state = st_ack;
						end else begin
							next_wdata = sh;
							next_wr = 1'b1;
							next_oe = 1'b1;
							next_state = st_ack;
						end
					end
				end
				st_ack: begin
					if (fall) begin
						next_oe = 1'b0;
						if (rnw) begin
							next_sh = rdata;
							next_oe = !rdata[7];
							next_cnt = 4'h1;
							next_rd = 1'b1;
							next_state = st_rd;
						end else begin
							if (next_wr == 1'b0 && ptr_done && cnt == 4'h0 && wr_stb == 1'b0)
								next_addr = addr;
							next_state = ptr_done ? st_wr : st_ptr;
						end
					end
					if (wr_stb)
						next_addr = addr + 8'h01;
				end
				st_rd: begin
					if (fall) begin
						if (cnt == 4'h8) begin
							next_oe = 1'b0;
							next_state = st_rack;
						end else begin
							next_oe = !sh[7 - cnt[2:0]];
							next_cnt = cnt + 4'h1;
						end
					end
				end
				st_rack: begin
					if (rise) begin
						next_addr = addr + 8'h01;
						next_state = sda_in ? st_idle : st_ack;
					end
				end
				default: next_state = st_idle;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= st_idle;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			sh <= 8'h00;
			cnt <= 4'h0;
			addr <= 8'h00;
			wdata <= 8'h00;
			rnw <= 1'b0;
			sda_oe <= 1'b0;
			wr_stb <= 1'b0;
			rd_stb <= 1'b0;
			ptr_done <= 1'b0;
		end else begin
			state <= next_state;
			scl_q <= next_scl_q;
			sda_q <= next_sda_q;
			sh <= next_sh;
			cnt <= next_cnt;
			addr <= next_addr;
			wdata <= next_wdata;
			rnw <= next_rnw;
			sda_oe <= next_oe;
			wr_stb <= next_wr;
			rd_stb <= next_rd;
			ptr_done <= next_ptr_done;
		end
	end
endmodule : misc_i2c_target
`default_nettype wire

// ### port_misc_control.sv
// port_misc_control.sv: discharge select, thermal sensor control, slow countdown timer, page select
// assumes i2c pins synchronous to clk and an external pull-up on the interrupt pin
`timescale 1ns/10ps
`default_nettype none
module port_misc_control #(
	parameter int tick_cycles = misc_ctrl_pkg::tick_cycles // cycles per timer count
) (
	input wire logic clk, // 25 MHz clock
	input wire logic rst, // synchronous reset
	input wire logic scl_in, // i2c clock level
	input wire logic sda_in, // i2c data level
	output logic sda_oe, // pulls sda low
	output logic int_oe, // pulls interrupt pin low
	input wire logic vconn_discharge_req, // vconn discharge condition
	input wire logic vbus_discharge_req, // vbus discharge condition
	input wire logic thermal_trip_raw, // detector output
	output logic vconn_discharge_on, // internal vconn discharge
	output logic vbus_discharge_on, // internal vbus discharge
	output logic thermal_sensor_on, // sensor enable
	output logic page_one // test page mapped
);
	logic wr_stb, rd_stb;
	logic [7:0] addr, wdata, rdata;
	logic [1:0] dis_bits, next_dis_bits;
	logic sens_en, next_sens_en, page, next_page, expired, next_expired;
	logic [7:0] lo_byte, next_lo_byte, hi_byte, next_hi_byte;
	logic [15:0] count, next_count;
	logic [$clog2(tick_cycles)-1:0] div, next_div;
	logic soft_rst, next_soft_rst, tick, clr;
	misc_i2c_target u_i2c (
		.clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .addr(addr), .wdata(wdata), .rdata(rdata)
	);
	assign clr = rst || soft_rst;
	assign tick = (div == '0) && (count != 16'h0000);
	always_comb begin
		next_dis_bits = dis_bits;
		next_sens_en = sens_en;
		next_page = page;
		next_lo_byte = lo_byte;
		next_hi_byte = hi_byte;
		next_count = count;
		next_div = div;
		next_expired = expired;
		next_soft_rst = 1'b0;
		if (count != 16'h0000)
			next_div = (div == '0) ? ($bits(div))'(tick_cycles - 1) : div - 1'b1;
		if (tick) begin
			next_count = count - 16'h0001;
			if (count == 16'h0001)
				next_expired = 1'b1;
		end
		if (wr_stb && !page) begin
			unique case (addr)
				misc_ctrl_pkg::discharge_path_control_addr: next_dis_bits = wdata[1:0];
				misc_ctrl_pkg::thermal_sensor_control_addr:
					next_sens_en = wdata[misc_ctrl_pkg::thermal_on_bit];
				misc_ctrl_pkg::slow_timer_low_byte_addr: next_lo_byte = wdata;
				misc_ctrl_pkg::slow_timer_high_byte_addr: begin
					next_hi_byte = wdata;
					next_count = {wdata, lo_byte};
					next_div = ($bits(div))'(tick_cycles - 1);
				end
				misc_ctrl_pkg::misc_status_addr:
					if (wdata[misc_ctrl_pkg::expired_bit] && !next_expired)
						next_expired = 1'b0;
					else if (wdata[misc_ctrl_pkg::expired_bit] && !(tick && count == 16'h0001))
						next_expired = 1'b0;
				misc_ctrl_pkg::soft_reset_control_addr:
					next_soft_rst = wdata[misc_ctrl_pkg::soft_reset_bit];
				default: begin
				end
			endcase
		end
		if (wr_stb && addr == misc_ctrl_pkg::register_page_choice_addr)
			next_page = wdata[misc_ctrl_pkg::page_bit];
	end
	always_ff @(posedge clk) begin
		if (clr) begin
			dis_bits <= 2'b00;
			sens_en <= 1'b0;
			page <= 1'b0;
			lo_byte <= misc_ctrl_pkg::reg_reset_value;
			hi_byte <= misc_ctrl_pkg::reg_reset_value;
			count <= 16'h0000;
			div <= '0;
			expired <= 1'b0;
			soft_rst <= 1'b0;
		end else begin
			dis_bits <= next_dis_bits;
			sens_en <= next_sens_en;
			page <= next_page;
			lo_byte <= next_lo_byte;
			hi_byte <= next_hi_byte;
			count <= next_count;
			div <= next_div;
			expired <= next_expired;
			soft_rst <= next_soft_rst;
		end
	end
	always_comb begin
		rdata = 8'h00;
		if (addr == misc_ctrl_pkg::register_page_choice_addr)
			rdata[misc_ctrl_pkg::page_bit] = page;
		else if (!page) begin
			unique case (addr)
				misc_ctrl_pkg::discharge_path_control_addr: rdata[1:0] = dis_bits;
				misc_ctrl_pkg::thermal_sensor_control_addr: begin
					rdata[misc_ctrl_pkg::thermal_on_bit] = sens_en;
					rdata[misc_ctrl_pkg::thermal_live_bit] = thermal_trip_raw;
				end
				misc_ctrl_pkg::slow_timer_low_byte_addr: rdata = lo_byte;
				misc_ctrl_pkg::slow_timer_high_byte_addr: rdata = hi_byte;
				misc_ctrl_pkg::misc_status_addr: rdata[misc_ctrl_pkg::expired_bit] = expired;
				misc_ctrl_pkg::soft_reset_control_addr:
					rdata[misc_ctrl_pkg::soft_reset_bit] = soft_rst;
				default: rdata = 8'h00;
			endcase
		end
	end
	assign vconn_discharge_on = vconn_discharge_req && !dis_bits[misc_ctrl_pkg::vconn_off_bit];
	assign vbus_discharge_on = vbus_discharge_req && !dis_bits[misc_ctrl_pkg::vbus_off_bit];
	assign thermal_sensor_on = sens_en;
	assign page_one = page;
	assign int_oe = expired;

	expire_flag_a: assert property (@(posedge clk) disable iff (clr)
		(tick && count == 16'h0001) |=> expired)
		else $error("expiry did not set flag");
	load_value_a: assert property (@(posedge clk) disable iff (clr)
		(wr_stb && !page && addr == misc_ctrl_pkg::slow_timer_high_byte_addr)
		|=> count == {$past(wdata), $past(lo_byte)})
		else $error("timer not loaded from bytes");
	low_stage_a: assert property (@(posedge clk) disable iff (clr)
		(wr_stb && addr == misc_ctrl_pkg::slow_timer_low_byte_addr && count == 16'h0000)
		|=> count == 16'h0000)
		else $error("low byte write changed timer");
	count_down_a: assert property (@(posedge clk) disable iff (clr)
		(tick && !wr_stb) |=> count == $past(count) - 16'h0001)
		else $error("timer did not decrement");
	zero_hold_a: assert property (@(posedge clk) disable iff (clr)
		(count == 16'h0000 && !wr_stb) |=> count == 16'h0000)
		else $error("stopped timer moved");
	live_trip_a: assert property (@(posedge clk) disable iff (clr)
		(!page && addr == misc_ctrl_pkg::thermal_sensor_control_addr)
		|-> rdata[misc_ctrl_pkg::thermal_live_bit] == thermal_trip_raw)
		else $error("live trip bit wrong");
	vbus_path_a: assert property (@(posedge clk) disable iff (clr)
		(wr_stb && !page && addr == misc_ctrl_pkg::discharge_path_control_addr) |=>
		vbus_discharge_on == (vbus_discharge_req && !wdata[misc_ctrl_pkg::vbus_off_bit]))
		else $error("vbus discharge select wrong");
	vconn_path_a: assert property (@(posedge clk) disable iff (clr)
		(wr_stb && !page && addr == misc_ctrl_pkg::discharge_path_control_addr) |=>
		vconn_discharge_on == (vconn_discharge_req && !wdata[misc_ctrl_pkg::vconn_off_bit]))
		else $error("vconn discharge select wrong");
	sensor_enable_a: assert property (@(posedge clk) disable iff (clr)
		(wr_stb && !page && addr == misc_ctrl_pkg::thermal_sensor_control_addr)
		|=> thermal_sensor_on == wdata[misc_ctrl_pkg::thermal_on_bit])
		else $error("sensor enable not taken");
	thermal_reserved_a: assert property (@(posedge clk) disable iff (clr)
		(!page && addr == misc_ctrl_pkg::thermal_sensor_control_addr)
		|-> (rdata & 8'hee) == 8'h00)
		else $error("thermal reserved bits set");
	reserved_zero_a: assert property (@(posedge clk) disable iff (clr)
		(!page && addr == misc_ctrl_pkg::discharge_path_control_addr)
		|-> (rdata & 8'hfc) == 8'h00)
		else $error("discharge reserved bits set");
	high_write_a: assert property (@(posedge clk) disable iff (clr)
		(wr_stb && !page && addr == misc_ctrl_pkg::slow_timer_high_byte_addr)
		|=> hi_byte == wdata)
		else $error("high byte not kept");
	high_readback_a: assert property (@(posedge clk) disable iff (clr)
		(!page && addr == misc_ctrl_pkg::slow_timer_high_byte_addr)
		|-> rdata == hi_byte)
		else $error("high byte readback wrong");
	prescale_step_a: assert property (@(posedge clk) disable iff (clr)
		(count != 16'h0000 && div != '0 && !wr_stb)
		|=> div == $past(div) - 1'b1)
		else $error("prescaler did not step");
	zero_load_a: assert property (@(posedge clk) disable iff (clr)
		(wr_stb && !page && addr == misc_ctrl_pkg::slow_timer_high_byte_addr
		&& wdata == 8'h00 && lo_byte == 8'h00 && !expired && count != 16'h0001)
		|=> (count == 16'h0000 && !expired))
		else $error("zero load did not stop timer");
	expire_clear_a: assert property (@(posedge clk) disable iff (clr)
		(wr_stb && !page && addr == misc_ctrl_pkg::misc_status_addr
		&& wdata[misc_ctrl_pkg::expired_bit] && !(tick && count == 16'h0001))
		|=> !expired)
		else $error("expired flag not cleared");
	int_drive_a: assert property (@(posedge clk) disable iff (clr)
		(tick && count == 16'h0001) |=> int_oe)
		else $error("interrupt pin not driven");
	page_select_a: assert property (@(posedge clk) disable iff (clr)
		(wr_stb && addr == misc_ctrl_pkg::register_page_choice_addr)
		|=> page_one == wdata[misc_ctrl_pkg::page_bit])
		else $error("page select not taken");
	page_hide_a: assert property (@(posedge clk) disable iff (clr)
		(page && addr != misc_ctrl_pkg::register_page_choice_addr)
		|-> rdata == 8'h00)
		else $error("page one register visible");
	soft_defaults_a: assert property (@(posedge clk) disable iff (rst)
		soft_rst |=> (!thermal_sensor_on && !int_oe && !expired
		&& lo_byte == misc_ctrl_pkg::reg_reset_value
		&& hi_byte == misc_ctrl_pkg::reg_reset_value))
		else $error("soft reset left state");
	soft_reset_a: assert property (@(posedge clk) disable iff (rst)
		soft_rst |=> (count == 16'h0000 && !page && !soft_rst && dis_bits == 2'b00))
		else $error("soft reset did not restore");
	readback_a: assert property (@(posedge clk) disable iff (clr)
		(!page && addr == misc_ctrl_pkg::slow_timer_low_byte_addr) |-> rdata == lo_byte)
		else $error("low byte readback wrong");
endmodule : port_misc_control
`default_nettype wire

// ### i2c_host_model.sv
// i2c_host_model.sv: bus master model issuing register writes and reads
// assumes a pulled-up sda resolved from both parties' pull-downs
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model (
	input wire logic clk, // system clock
	input wire logic dev_sda_oe, // device pulls sda low
	output logic scl, // bus clock level
	output logic sda, // resolved data level
	output logic ack // ack of the last byte sent
);
	logic m_low;
	assign sda = !(m_low | dev_sda_oe);
	initial begin
		scl = 1'b1;
		m_low = 1'b0;
		ack = 1'b0;
	end
	task automatic hold();
		repeat (4) @(posedge clk);
	endtask : hold
	// one bit: data set while scl low, sampled while high; 12 clk cycles per bit
	task automatic bit_io(input logic b, output logic r);
		m_low <= !b;
		hold();
		scl <= 1'b1;
		hold();
		r = sda;
		scl <= 1'b0;
		hold();
	endtask : bit_io
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(last, r);
		ack = !r;
	endtask : xfer
	// also serves as repeated start
	task automatic start();
		m_low <= 1'b0;
		hold();
		scl <= 1'b1;
		hold();
		m_low <= 1'b1;
		hold();
		scl <= 1'b0;
		hold();
	endtask : start
	task automatic stop();
		m_low <= 1'b1;
		hold();
		scl <= 1'b1;
		hold();
		m_low <= 1'b0;
		hold();
	endtask : stop
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		start();
		xfer({misc_ctrl_pkg::i2c_target_address[6:0], 1'b0}, 1'b1, q);
		xfer(a, 1'b1, q);
		xfer(d, 1'b1, q);
		stop();
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] q;
		start();
		xfer({misc_ctrl_pkg::i2c_target_address[6:0], 1'b0}, 1'b1, q);
		xfer(a, 1'b1, q);
		start();
		xfer({misc_ctrl_pkg::i2c_target_address[6:0], 1'b1}, 1'b1, q);
		xfer(8'hff, 1'b1, d);
		stop();
	endtask : rd
endmodule : i2c_host_model
`default_nettype wire

// ### tb.sv
// tb.sv: self-checking bench for the misc control bank
// assumes the host model as i2c master and a timer scaled to 4 cycles per count
`timescale 1ns/10ps
`default_nettype none
module tb;
	localparam int tk = 4;
	logic clk, rst, scl, sda, sda_oe, int_oe, vc_req, vb_req, trip, vc_on, vb_on, th_on, pg;
	logic ack;
	logic [7:0] q;
	logic [31:0] seed = 32'h175f;
	int err_total = 0, samples_checked = 0, t0, cyc = 0;
	port_misc_control #(.tick_cycles(tk)) dut_u (.clk(clk), .rst(rst), .scl_in(scl),
		.sda_in(sda), .sda_oe(sda_oe), .int_oe(int_oe), .vconn_discharge_req(vc_req),
		.vbus_discharge_req(vb_req), .thermal_trip_raw(trip), .vconn_discharge_on(vc_on),
		.vbus_discharge_on(vb_on), .thermal_sensor_on(th_on), .page_one(pg));
	i2c_host_model host_u (.clk(clk), .dev_sda_oe(sda_oe), .scl(scl), .sda(sda), .ack(ack));
	initial begin
		clk = 1'b0;
		forever #20 clk = !clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [7:0] thermal_exp(input logic [7:0] v, input logic t);
		return {3'h0, t, 3'h0, v[0]};
	endfunction : thermal_exp
	task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
		host_u.rd(a, q);
		samples_checked++;
		if (q !== e) begin
			err_total++;
			$display("[FAIL] %0t reg %h read %h want %h", $time, a, q, e);
		end
	endtask : chk_reg
	task automatic chk_pin(input logic g, input logic e, input int id);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t pin check %0d got %b", $time, id, g);
		end
	endtask : chk_pin
	task automatic results();
		$display("mismatches %0d of %0d checks", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results
	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		results();
	end
	initial begin
		logic [7:0] v;
		logic [15:0] n;
		rst = 1'b1;
		vc_req = 1'b0;
		vb_req = 1'b0;
		trip = 1'b0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		chk_reg(8'h98, 8'h00);
		chk_reg(8'h99, 8'h00);
		chk_reg(8'ha0, 8'h00);
		chk_reg(8'ha1, 8'h00);
		chk_reg(8'hff, 8'h00);
		seed = xs(seed);
		v = seed[7:0];
		host_u.wr(8'h98, v);
		chk_reg(8'h98, v & 8'h03);
		for (int r = 0; r < 4; r++) begin
			vc_req <= r[1];
			vb_req <= r[0];
			@(posedge clk);
			@(posedge clk);
			chk_pin(vc_on, r[1] & !v[1], 1);
			chk_pin(vb_on, r[0] & !v[0], 2);
		end
		trip <= seed[8];
		host_u.wr(8'h99, 8'hff);
		chk_pin(th_on, 1'b1, 3);
		chk_reg(8'h99, thermal_exp(8'hff, seed[8]));
		trip <= !seed[8];
		chk_reg(8'h99, thermal_exp(8'hff, !seed[8]));
		v = seed[23:16] | 8'h01;
		host_u.wr(8'ha0, v);
		repeat (1100) @(posedge clk);
		chk_pin(int_oe, 1'b0, 4);
		n = {8'h02, v};
		host_u.wr(8'ha1, 8'h02);
		t0 = cyc;
		chk_reg(8'ha0, v);
		chk_reg(8'ha1, 8'h02);
		chk_pin(int_oe, 1'b0, 5);
		for (int k = 0; k < 5000 && int_oe !== 1'b1; k++) @(posedge clk);
		chk_pin(int_oe, 1'b1, 6);
		chk_pin((cyc - t0) <= n * tk && (cyc - t0) + 40 >= n * tk, 1'b1, 7);
		chk_reg(8'ha2, 8'h01);
		host_u.wr(8'ha2, 8'h01);
		chk_pin(int_oe, 1'b0, 8);
		host_u.wr(8'ha1, 8'h01);
		host_u.wr(8'ha0, 8'h00);
		host_u.wr(8'ha1, 8'h00);
		repeat (2500) @(posedge clk);
		chk_pin(int_oe, 1'b0, 9);
		host_u.wr(8'hff, 8'hff);
		chk_pin(pg, 1'b1, 10);
		chk_reg(8'hff, 8'h01);
		chk_reg(8'h99, 8'h00);
		host_u.wr(8'hff, 8'h00);
		chk_pin(pg, 1'b0, 11);
		host_u.wr(8'h98, 8'h03);
		host_u.wr(8'h99, 8'h01);
		host_u.wr(8'ha3, 8'h20);
		chk_reg(8'h98, 8'h00);
		chk_reg(8'ha3, 8'h00);
		chk_pin(th_on, 1'b0, 12);
		results();
	end
endmodule : tb
`default_nettype wire
